// file: css_pkg.sv
// shared constants and types of the clock synthesizer smbus register bank
package css_pkg;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam int CSS_NUM_REGS = 14;
  localparam logic [7:0] CSS_IDX_FREQ_SPREAD = 8'h00;
  localparam logic [7:0] CSS_IDX_OUT_MISC = 8'h01;
  localparam logic [7:0] CSS_IDX_GFX_REQ_B = 8'h02;
  localparam logic [7:0] CSS_IDX_SRC_ENABLE = 8'h03;
  localparam logic [7:0] CSS_IDX_REQ_A_C = 8'h04;
  localparam logic [7:0] CSS_IDX_IO_SRC_SEL = 8'h05;
  localparam logic [7:0] CSS_IDX_PART_ID = 8'h06;
  localparam logic [7:0] CSS_IDX_REV_MAKER = 8'h07;
  localparam logic [7:0] CSS_IDX_READBACK = 8'h08;
  localparam logic [7:0] CSS_IDX_STR_GFX = 8'h09;
  localparam logic [7:0] CSS_IDX_DIV_STR = 8'h0a;
  localparam logic [7:0] CSS_IDX_PLL_MN_HI = 8'h0b;
  localparam logic [7:0] CSS_IDX_PLL_N_LO = 8'h0c;
  localparam logic [7:0] CSS_IDX_PLL_SPREAD = 8'h0d;
  // ----------------------------------------
  // reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] CSS_RST_B0 = 8'h00;
  localparam logic [7:0] CSS_RST_B1 = 8'hff;
  localparam logic [7:0] CSS_RST_B2 = 8'h30;
  localparam logic [7:0] CSS_RST_B3 = 8'hff;
  localparam logic [7:0] CSS_RST_B4 = 8'h00;
  localparam logic [7:0] CSS_RST_B5 = 8'ha0;
  localparam logic [7:0] CSS_RST_B8 = 8'h09;
  localparam logic [7:0] CSS_RST_B9 = 8'he0;
  localparam logic [7:0] CSS_RST_B10 = 8'h60;
  localparam logic [7:0] CSS_RST_PLL = 8'h00;
  localparam logic [7:0] CSS_MASK_ALL = 8'hff;
  localparam logic [7:0] CSS_MASK_B2 = 8'h3a;
  localparam logic [7:0] CSS_MASK_B3 = 8'hf5;
  localparam logic [7:0] CSS_MASK_B4 = 8'he7;
  localparam logic [7:0] CSS_MASK_B5 = 8'hef;
  localparam logic [7:0] CSS_MASK_B9 = 8'hef;
  localparam logic [7:0] CSS_MASK_B10 = 8'he0;
  localparam logic [7:0] CSS_MASK_NONE = 8'h00;
  // ----------------------------------------
  // smbus addresses and field positions
  // ----------------------------------------
  localparam logic [7:0] CSS_ADDR_WRITE = 8'hd2;
  localparam logic [7:0] CSS_ADDR_READ = 8'hd3;
  localparam logic [6:0] CSS_ADDR7 = 7'h69;
  localparam logic [3:0] CSS_LAST_BIT = 4'h7;
  localparam logic [3:0] CSS_ACK_SLOT = 4'h8;
  localparam int CSS_B0_ORIGIN = 7;
  localparam int CSS_B0_GFX_SS = 6;
  localparam int CSS_B0_SRC_SS = 5;
  localparam int CSS_B0_CPU_SS = 4;
  localparam int CSS_B10_MN_EN = 7;
  // ----------------------------------------
  // transfer states, gray along write path
  // ----------------------------------------
  typedef enum logic [2:0] {
    CSS_ST_IDLE = 3'b000,
    CSS_ST_ADDR = 3'b001,
    CSS_ST_INDEX = 3'b011,
    CSS_ST_COUNT = 3'b010,
    CSS_ST_WDATA = 3'b110,
    CSS_ST_READ = 3'b111
  } css_state_t;
endpackage

// file: css_xfer_if.sv
// byte-level handover between the smbus link engine and the register core
`timescale 1ns/1ps
`default_nettype none
interface css_xfer_if;
  logic start_tgl;
  logic rx_tgl;
  logic load_tgl;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  modport link (
    output start_tgl,
    output rx_tgl,
    output load_tgl,
    output rx_byte,
    input tx_byte
  );
  modport core (
    input start_tgl,
    input rx_tgl,
    input load_tgl,
    input rx_byte,
    output tx_byte
  );
endinterface
`default_nettype wire

// file: css_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module css_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule
`default_nettype wire

// file: css_link.sv
// smbus bit engine on the smbus clock
`timescale 1ns/1ps
`default_nettype none
module css_link
  import css_pkg::*;
(
  // link clock and reset
  input wire logic smbclk,
  input wire logic rst,
  // data pin
  input wire logic sda_in,
  output logic sda_oe_n,
  // byte handover
  css_xfer_if.link xfer
);
  logic lrst;
  logic sda_hi_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic active_r, addr_ph_r, tx_mode_r;
  logic start_tgl_r, rx_tgl_r, load_tgl_r;
  logic [7:0] rx_byte_r;
  logic start_cond, stop_cond;
  logic [7:0] rx_full;

  css_sync #(.WIDTH(1)) u_rst_sync (.clk(smbclk), .d(rst), .q(lrst));

  // sda sampled high-phase start, compared at the falling edge
  always_ff @(posedge smbclk)
  begin
    sda_hi_r <= sda_in;
  end

  // a start right after a stop is seen only after one more scl pulse
  assign start_cond = sda_hi_r & ~sda_in;
  assign stop_cond = ~sda_hi_r & sda_in;
  assign rx_full = {shift_r[6:0], sda_hi_r};

  always_ff @(negedge smbclk)
  begin
    if (lrst)
    begin
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      active_r <= 1'b0;
      addr_ph_r <= 1'b0;
      tx_mode_r <= 1'b0;
      sda_oe_n <= 1'b1;
      start_tgl_r <= 1'b0;
      rx_tgl_r <= 1'b0;
      load_tgl_r <= 1'b0;
      rx_byte_r <= 8'h00;
    end
    else if (start_cond)
    begin
      active_r <= 1'b1;
      addr_ph_r <= 1'b1;
      tx_mode_r <= 1'b0;
      cnt_r <= 4'h0;
      sda_oe_n <= 1'b1;
      start_tgl_r <= ~start_tgl_r;
    end
    else if (stop_cond)
    begin
      active_r <= 1'b0;
      tx_mode_r <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (active_r)
    begin
      if (cnt_r == CSS_ACK_SLOT)
      begin
        cnt_r <= 4'h0;
        if (tx_mode_r && !sda_hi_r)
        begin
          shift_r <= xfer.tx_byte;
          sda_oe_n <= xfer.tx_byte[7];
          load_tgl_r <= ~load_tgl_r;
        end
        else
        begin
          sda_oe_n <= 1'b1;
          if (tx_mode_r)
            active_r <= 1'b0;
        end
      end
      else if (tx_mode_r)
      begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == CSS_LAST_BIT)
          sda_oe_n <= 1'b1;
        else
        begin
          sda_oe_n <= shift_r[6];
          shift_r <= {shift_r[6:0], 1'b0};
        end
      end
      else
      begin
        cnt_r <= cnt_r + 4'h1;
        shift_r <= rx_full;
        if (cnt_r == CSS_LAST_BIT)
        begin
          if (addr_ph_r)
          begin
            addr_ph_r <= 1'b0;
            if (rx_full[7:1] == CSS_ADDR7)
            begin
              sda_oe_n <= 1'b0;
              tx_mode_r <= rx_full[0];
              rx_byte_r <= rx_full;
              rx_tgl_r <= ~rx_tgl_r;
            end
            else
              active_r <= 1'b0;
          end
          else
          begin
            sda_oe_n <= 1'b0;
            rx_byte_r <= rx_full;
            rx_tgl_r <= ~rx_tgl_r;
          end
        end
      end
    end
  end

  assign xfer.start_tgl = start_tgl_r;
  assign xfer.rx_tgl = rx_tgl_r;
  assign xfer.load_tgl = load_tgl_r;
  assign xfer.rx_byte = rx_byte_r;
endmodule
`default_nettype wire

// file: css_regbank.sv
// smbus control and status register bank of the clock synthesizer
`timescale 1ns/1ps
`default_nettype none
module css_regbank
  import css_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [7:0] PART_IDENTITY = 8'h5a,
  parameter logic [3:0] REVISION_CODE = 4'h3,
  parameter logic [3:0] MAKER_CODE = 4'h9
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // smbus pins
  input wire logic smbclk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // strap and request pins
  input wire logic [2:0] strap_in,
  input wire logic request_pin_first_n,
  input wire logic request_pin_second_n,
  input wire logic request_pin_third_n,
  // frequency and spread controls
  output logic freq_select_origin,
  output logic graphics_spread_on,
  output logic serial_ref_spread_on,
  output logic processor_spread_on,
  output logic [3:0] processor_rate_code,
  output logic [3:0] serial_ref_rate_code,
  output logic [3:0] graphics_rate_code,
  // output enables, graphics and serial reference pairs after request gating
  output logic [1:0] usb_rate_out_enable,
  output logic [2:0] reference_out_enable,
  output logic link_clock_enable,
  output logic [1:0] processor_pair_enable,
  output logic [1:0] graphics_pair_enable,
  output logic [5:0] serial_ref_pair_enable,
  // electrical and pll controls
  output logic [2:0] out_voltage_field,
  output logic [2:0] reference_drive_level,
  output logic [1:0] usb_drive_level,
  output logic divider_prog_on,
  output logic [9:0] feedback_divider,
  output logic [5:0] input_divider,
  output logic [7:0] spread_amount_field
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  css_xfer_if xfer ();
  logic [8:0] pin_sync;
  logic [2:0] tgl_prev_r;
  logic start_ev, rx_ev, load_ev;
  logic [2:0] strap_sync;
  logic [2:0] req_n_sync;
  logic [2:0] strap_latch_r;
  logic [7:0] regs_r [0:CSS_NUM_REGS-1];
  css_state_t state_r;
  logic [7:0] idx_r;
  logic [7:0] remain_r;
  logic [7:0] tx_byte_r;
  logic wr_en;

  // ----------------------------------------
  // register decode helpers
  // ----------------------------------------
  function automatic logic [7:0] reset_val(input int i);
    case (i)
      0: reset_val = CSS_RST_B0;
      1: reset_val = CSS_RST_B1;
      2: reset_val = CSS_RST_B2;
      3: reset_val = CSS_RST_B3;
      4: reset_val = CSS_RST_B4;
      5: reset_val = CSS_RST_B5;
      8: reset_val = CSS_RST_B8;
      9: reset_val = CSS_RST_B9;
      10: reset_val = CSS_RST_B10;
      default: reset_val = CSS_RST_PLL;
    endcase
  endfunction

  // read-only and reserved positions never take a write
  function automatic logic [7:0] wr_mask(input int i);
    case (i)
      2: wr_mask = CSS_MASK_B2;
      3: wr_mask = CSS_MASK_B3;
      4: wr_mask = CSS_MASK_B4;
      5: wr_mask = CSS_MASK_B5;
      6: wr_mask = CSS_MASK_NONE;
      7: wr_mask = CSS_MASK_NONE;
      9: wr_mask = CSS_MASK_B9;
      10: wr_mask = CSS_MASK_B10;
      default: wr_mask = CSS_MASK_ALL;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    if (idx == CSS_IDX_PART_ID)
      rd_byte = PART_IDENTITY;
    else if (idx == CSS_IDX_REV_MAKER)
      rd_byte = {REVISION_CODE, MAKER_CODE};
    else if (idx < 8'(CSS_NUM_REGS))
      rd_byte = regs_r[idx[3:0]];
    else
      rd_byte = 8'h00;
  endfunction

  // ----------------------------------------
  // link engine and crossings
  // ----------------------------------------
  css_link u_link (
    .smbclk(smbclk),
    .rst(rst),
    .sda_in(sda_in),
    .sda_oe_n(sda_oe_n),
    .xfer(xfer)
  );

  css_sync #(.WIDTH(9)) u_pin_sync (
    .clk(clock),
    .d({strap_in, request_pin_third_n, request_pin_second_n, request_pin_first_n,
        xfer.load_tgl, xfer.rx_tgl, xfer.start_tgl}),
    .q(pin_sync)
  );

  assign strap_sync = pin_sync[8:6];
  assign req_n_sync = pin_sync[5:3];
  assign start_ev = pin_sync[0] ^ tgl_prev_r[0];
  assign rx_ev = pin_sync[1] ^ tgl_prev_r[1];
  assign load_ev = pin_sync[2] ^ tgl_prev_r[2];
  // tx word is held stable for nine smbus clocks before the link samples it
  assign xfer.tx_byte = tx_byte_r;

  // follows the toggles through reset, so no false event comes after it
  always_ff @(posedge clock)
  begin
    tgl_prev_r <= pin_sync[2:0];
  end

  // straps are caught while reset is held
  always_ff @(posedge clock)
  begin
    if (rst)
      strap_latch_r <= strap_sync;
  end

  always_ff @(posedge clock)
  begin
    sda_out <= 1'b0;
  end

  // ----------------------------------------
  // transfer sequencing
  // ----------------------------------------
  assign wr_en = rx_ev && (state_r == CSS_ST_WDATA) && (remain_r != 8'h00);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= CSS_ST_IDLE;
      idx_r <= 8'h00;
      remain_r <= 8'h00;
    end
    else if (start_ev)
      state_r <= CSS_ST_ADDR;
    else if (rx_ev)
    begin
      case (state_r)
        CSS_ST_ADDR:
        begin
          if (xfer.rx_byte == CSS_ADDR_WRITE)
            state_r <= CSS_ST_INDEX;
          else if (xfer.rx_byte == CSS_ADDR_READ)
            state_r <= CSS_ST_READ;
          else
            state_r <= CSS_ST_IDLE;
        end
        CSS_ST_INDEX:
        begin
          idx_r <= xfer.rx_byte;
          state_r <= CSS_ST_COUNT;
        end
        CSS_ST_COUNT:
        begin
          remain_r <= xfer.rx_byte;
          state_r <= CSS_ST_WDATA;
        end
        CSS_ST_WDATA:
        begin
          if (remain_r != 8'h00)
          begin
            idx_r <= idx_r + 8'h01;
            remain_r <= remain_r - 8'h01;
          end
        end
        default:
          state_r <= state_r;
      endcase
    end
    else if (load_ev && state_r == CSS_ST_READ)
      idx_r <= idx_r + 8'h01;
  end

  // count goes out first, then bytes from the requested index
  always_ff @(posedge clock)
  begin
    if (rst)
      tx_byte_r <= 8'h00;
    else if (start_ev)
      tx_byte_r <= regs_r[CSS_IDX_READBACK[3:0]];
    else if (load_ev && state_r == CSS_ST_READ)
      tx_byte_r <= rd_byte(idx_r);
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  generate
    for (genvar i = 0; i < CSS_NUM_REGS; i++)
    begin : g_reg
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          if (i == 0)
            regs_r[i] <= reset_val(i) | {5'b00000, strap_sync};
          else
            regs_r[i] <= reset_val(i);
        end
        else if (wr_en && idx_r == 8'(i))
          regs_r[i] <= (regs_r[i] & ~wr_mask(i)) | (xfer.rx_byte & wr_mask(i));
      end
    end
  endgenerate

  // ----------------------------------------
  // frequency, spread and pll outputs
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    freq_select_origin <= regs_r[0][CSS_B0_ORIGIN];
    graphics_spread_on <= regs_r[0][CSS_B0_GFX_SS];
    serial_ref_spread_on <= regs_r[0][CSS_B0_SRC_SS];
    processor_spread_on <= regs_r[0][CSS_B0_CPU_SS];
    if (regs_r[0][CSS_B0_ORIGIN])
      processor_rate_code <= regs_r[0][3:0];
    else
      processor_rate_code <= {1'b0, strap_latch_r};
    serial_ref_rate_code <= regs_r[5][3:0];
    graphics_rate_code <= regs_r[9][3:0];
    out_voltage_field <= regs_r[5][7:5];
    reference_drive_level <= {regs_r[9][7], regs_r[10][6:5]};
    usb_drive_level <= regs_r[9][6:5];
    divider_prog_on <= regs_r[10][CSS_B10_MN_EN];
    feedback_divider <= {regs_r[11][6], regs_r[11][7], regs_r[12]};
    input_divider <= regs_r[11][5:0];
    spread_amount_field <= regs_r[13];
  end

  // ----------------------------------------
  // output enables with request gating
  // ----------------------------------------
  // request pins are active low; a steered pair runs only while requested
  always_ff @(posedge clock)
  begin
    usb_rate_out_enable <= regs_r[1][7:6];
    reference_out_enable <= regs_r[1][5:3];
    link_clock_enable <= regs_r[1][2];
    processor_pair_enable <= regs_r[1][1:0];
    graphics_pair_enable[1] <= regs_r[2][5] & (~regs_r[4][2] | ~req_n_sync[2]);
    graphics_pair_enable[0] <= regs_r[2][4] & (~regs_r[4][1] | ~req_n_sync[2]);
    serial_ref_pair_enable[5] <= regs_r[3][7] & (~regs_r[4][7] | ~req_n_sync[0]);
    serial_ref_pair_enable[4] <= regs_r[3][6] & (~regs_r[4][6] | ~req_n_sync[0]);
    serial_ref_pair_enable[3] <= regs_r[3][5] & (~regs_r[4][5] | ~req_n_sync[0]);
    serial_ref_pair_enable[2] <= regs_r[3][4] & (~regs_r[2][3] | ~req_n_sync[1]);
    serial_ref_pair_enable[1] <= regs_r[3][2] & (~regs_r[2][1] | ~req_n_sync[1]);
    serial_ref_pair_enable[0] <= regs_r[3][0] & (~regs_r[4][0] | ~req_n_sync[2]);
  end
endmodule
`default_nettype wire

// file: css_regbank_assertions.sv
// concurrent checks on the ports of the smbus register bank
`timescale 1ns/1ps
`default_nettype none
module css_regbank_assertions
  import css_pkg::*;
(
  // clocks and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic smbclk,
  // smbus pin
  input wire logic sda_in,
  input wire logic sda_oe_n,
  // watched outputs
  input wire logic freq_select_origin,
  input wire logic graphics_spread_on,
  input wire logic serial_ref_spread_on,
  input wire logic processor_spread_on,
  input wire logic [3:0] processor_rate_code,
  input wire logic [1:0] usb_rate_out_enable,
  input wire logic [2:0] reference_out_enable,
  input wire logic [1:0] graphics_pair_enable,
  input wire logic [5:0] serial_ref_pair_enable,
  input wire logic [2:0] out_voltage_field,
  input wire logic [2:0] reference_drive_level
);
  // ----------------------------------------
  // frame tracking on the wire
  // ----------------------------------------
  // start seen asynchronously, handed over as a toggle
  logic st_tgl = 1'b0;
  logic seen_r = 1'b0;
  logic first_r = 1'b0;
  logic rd_r = 1'b0;
  logic hit_r = 1'b0;
  logic [3:0] cnt_r = 4'h0;
  logic [7:0] sh_r = 8'h00;
  logic new_w;
  assign new_w = st_tgl ^ seen_r;
  always @(negedge sda_in) if (smbclk) st_tgl <= ~st_tgl;
  always_ff @(posedge smbclk)
  begin
    seen_r <= st_tgl;
    sh_r <= {sh_r[6:0], sda_in};
    cnt_r <= (new_w || cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
    first_r <= new_w ? 1'b1 : (cnt_r == 4'h9 ? 1'b0 : first_r);
    if (first_r && cnt_r == 4'h8)
    begin
      rd_r <= sh_r[0];
      hit_r <= sh_r[7:1] == CSS_ADDR7;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_rst_en;
    @(posedge clock) disable iff (rst) $fell(rst) |-> usb_rate_out_enable == 2'h3 &&
      reference_out_enable == 3'h7 && graphics_pair_enable == 2'h3 &&
      serial_ref_pair_enable == 6'h3f;
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("enable reset wrong");
  property p_rst_volt;
    @(posedge clock) disable iff (rst) $fell(rst) |->
      out_voltage_field == 3'h5 && reference_drive_level == 3'h7;
  endproperty
  a_rst_volt: assert property (p_rst_volt) else $error("field reset wrong");
  property p_rst_zero;
    @(posedge clock) disable iff (rst) $fell(rst) |-> !freq_select_origin &&
      !graphics_spread_on && !serial_ref_spread_on && !processor_spread_on;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("spread reset wrong");
  property p_origin_code;
    @(posedge clock) disable iff (rst) !freq_select_origin |-> !processor_rate_code[3];
  endproperty
  a_origin_code: assert property (p_origin_code) else $error("strap code wrong");
  property p_addr_ack;
    @(posedge smbclk) disable iff (rst)
      first_r && cnt_r == 4'h8 && sh_r[7:1] == CSS_ADDR7 |-> !sda_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_addr_refuse;
    @(posedge smbclk) disable iff (rst)
      first_r && cnt_r == 4'h8 && sh_r[7:1] != CSS_ADDR7 |-> sda_oe_n [*2];
  endproperty
  a_addr_refuse: assert property (p_addr_refuse) else $error("foreign address acked");
  property p_wr_ack;
    @(posedge smbclk) disable iff (rst) !first_r && hit_r && !rd_r && cnt_r == 4'h8 |-> !sda_oe_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
  property p_rd_release;
    @(posedge smbclk) disable iff (rst) !first_r && hit_r && rd_r && cnt_r == 4'h8 |-> sda_oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("host ack slot driven");
  c_write: cover property (@(posedge smbclk) first_r && cnt_r == 4'h8 && sh_r == CSS_ADDR_WRITE);
  c_read: cover property (@(posedge smbclk) first_r && cnt_r == 4'h8 && sh_r == CSS_ADDR_READ);
  c_origin: cover property (@(posedge clock) $rose(freq_select_origin));
endmodule
bind css_regbank css_regbank_assertions chk_u (.clock, .rst, .smbclk, .sda_in, .sda_oe_n,
  .freq_select_origin, .graphics_spread_on, .serial_ref_spread_on, .processor_spread_on,
  .processor_rate_code, .usb_rate_out_enable, .reference_out_enable, .graphics_pair_enable,
  .serial_ref_pair_enable, .out_voltage_field, .reference_drive_level);
`default_nettype wire

// file: css_host.sv
// smbus host model issuing block writes and block reads
`timescale 1ns/1ps
`default_nettype none
module css_host
  import css_pkg::*;
(
  // smbus lines
  output logic smbclk,
  output logic sda_host,
  input wire logic sda_wire
);
  // scl stands high between frames
  initial
  begin
    smbclk = 1'b1;
    sda_host = 1'b1;
  end
  // sda only moves while scl is low
  task automatic bit_x(input logic b, output logic s);
    sda_host = b;
    #40 smbclk = 1'b1;
    s = sda_wire;
    #80 smbclk = 1'b0;
    #40;
  endtask
  task automatic start_c();
    sda_host = 1'b1;
    #40 smbclk = 1'b1;
    #40 sda_host = 1'b0;
    #40 smbclk = 1'b0;
    #40;
  endtask
  // one scl pulse after the stop lets the link see the next start
  task automatic stop_c();
    sda_host = 1'b0;
    #40 smbclk = 1'b1;
    #40 sda_host = 1'b1;
    #40 smbclk = 1'b0;
    #80 smbclk = 1'b1;
    #40;
  endtask
  // idle pulses let the link side see reset
  task automatic pulses(input int n);
    repeat (n)
    begin
      #80 smbclk = 1'b0;
      #80 smbclk = 1'b1;
    end
  endtask
  task automatic put_b(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], s);
    bit_x(1'b1, s);
    ok = ok & ~s;
  endtask
  task automatic get_b(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, s);
      b[i] = s;
    end
    bit_x(nack, s);
  endtask
  task automatic write_blk(input logic [7:0] adr, input logic [7:0] idx,
    input logic [7:0] cnt, input logic [7:0] d [16], output logic ok);
    ok = 1'b1;
    start_c();
    put_b(adr, ok); // address, index, count, data
    put_b(idx, ok);
    put_b(cnt, ok);
    for (int k = 0; k < cnt; k++)
      put_b(d[k], ok);
    stop_c();
  endtask
  task automatic read_blk(input logic [7:0] idx, input int n, output logic [7:0] cb,
    output logic [7:0] q [16], output logic ok);
    ok = 1'b1;
    start_c();
    put_b(CSS_ADDR_WRITE, ok); // index, restart, read address
    put_b(idx, ok);
    start_c();
    put_b(CSS_ADDR_READ, ok);
    get_b(1'b0, cb);
    for (int k = 0; k < n; k++)
      get_b(k == n - 1, q[k]); // last byte not acked
    stop_c();
  endtask
endmodule
`default_nettype wire

// file: clock_synth_smbus_control_regs_tb.sv
// self-checking bench for the smbus register bank
`timescale 1ns/1ps
`default_nettype none
module clock_synth_smbus_control_regs_tb
  import css_pkg::*;
;
  // arbitrary identity values
  localparam logic [7:0] ID_P = 8'h3c;
  localparam logic [3:0] RV_P = 4'h6;
  localparam logic [3:0] MK_P = 4'hc;
  // corner writes: index and value
  localparam logic [11:0] CV [11] = '{12'h070, 12'h040, 12'h020, 12'h010, 12'h08a,
    12'h2ff, 12'h300, 12'h4ff, 12'h6ff, 12'h7ff, 12'hbc5};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic smbclk, sda_host, sda_wire, sda_out, sda_oe_n;
  logic [2:0] strap_in;
  logic request_pin_first_n = 1'b1, request_pin_second_n = 1'b1, request_pin_third_n = 1'b1;
  logic freq_select_origin, graphics_spread_on, serial_ref_spread_on, processor_spread_on;
  logic link_clock_enable, divider_prog_on;
  logic [3:0] processor_rate_code, serial_ref_rate_code, graphics_rate_code;
  logic [1:0] usb_rate_out_enable, processor_pair_enable, graphics_pair_enable, usb_drive_level;
  logic [2:0] reference_out_enable, out_voltage_field, reference_drive_level;
  logic [5:0] serial_ref_pair_enable, input_divider;
  logic [9:0] feedback_divider;
  logic [7:0] spread_amount_field, cb;
  logic [64:0] outs;
  logic [7:0] sh [14];
  logic [7:0] d [16];
  logic [7:0] q [16];
  logic ok;
  int fails = 0;
  int num_checks = 0;
  always #12.5 clock = ~clock;
  // pull-up wire; an undriven enable counts as released
  assign sda_wire = (sda_oe_n === 1'b0) ? (sda_host & sda_out) : sda_host;
  assign outs = {freq_select_origin, graphics_spread_on, serial_ref_spread_on,
    processor_spread_on, processor_rate_code, serial_ref_rate_code, graphics_rate_code,
    usb_rate_out_enable, reference_out_enable, link_clock_enable, processor_pair_enable,
    graphics_pair_enable, serial_ref_pair_enable, out_voltage_field, reference_drive_level,
    usb_drive_level, divider_prog_on, feedback_divider, input_divider, spread_amount_field};
  css_regbank #(.PART_IDENTITY(ID_P), .REVISION_CODE(RV_P), .MAKER_CODE(MK_P)) dut_u (
    .clock, .rst, .smbclk, .sda_in(sda_wire), .sda_out, .sda_oe_n, .strap_in,
    .request_pin_first_n, .request_pin_second_n, .request_pin_third_n,
    .freq_select_origin, .graphics_spread_on, .serial_ref_spread_on, .processor_spread_on,
    .processor_rate_code, .serial_ref_rate_code, .graphics_rate_code, .usb_rate_out_enable,
    .reference_out_enable, .link_clock_enable, .processor_pair_enable, .graphics_pair_enable,
    .serial_ref_pair_enable, .out_voltage_field, .reference_drive_level, .usb_drive_level,
    .divider_prog_on, .feedback_divider, .input_divider, .spread_amount_field);
  css_host host_u (.smbclk, .sda_host, .sda_wire);
  function automatic logic [7:0] msk(input int i);
    case (i)
      2: return CSS_MASK_B2;
      3: return CSS_MASK_B3;
      4: return CSS_MASK_B4;
      5, 9: return CSS_MASK_B5;
      6, 7: return CSS_MASK_NONE;
      10: return CSS_MASK_B10;
      default: return CSS_MASK_ALL;
    endcase
  endfunction
  // pin low asks for its clock
  function automatic logic [64:0] exp_outs();
    logic [7:0] b [14];
    logic p1, p2, p3;
    b = sh;
    p1 = ~request_pin_first_n;
    p2 = ~request_pin_second_n;
    p3 = ~request_pin_third_n;
    return {b[0][7:4], b[0][7] ? b[0][3:0] : {1'b0, strap_in}, b[5][3:0], b[9][3:0], b[1],
      b[2][5] & (~b[4][2] | p3), b[2][4] & (~b[4][1] | p3), b[3][7] & (~b[4][7] | p1),
      b[3][6] & (~b[4][6] | p1), b[3][5] & (~b[4][5] | p1), b[3][4] & (~b[2][3] | p2),
      b[3][2] & (~b[2][1] | p2), b[3][0] & (~b[4][0] | p3), b[5][7:5], b[9][7], b[10][6:5],
      b[9][6:5], b[10][7], b[11][6], b[11][7], b[12], b[11][5:0], b[13]};
  endfunction
  task automatic check(input logic [64:0] got, input logic [64:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one write, new pin levels, then read back and compare all outputs
  task automatic round(input logic [7:0] adr, input int idx, input int cnt);
    logic [7:0] m;
    host_u.write_blk(adr, idx[7:0], cnt[7:0], d, ok);
    check(ok, adr == CSS_ADDR_WRITE); // acked only at own address
    for (int k = 0; k < cnt; k++)
      if (adr == CSS_ADDR_WRITE && idx + k < 14)
      begin
        m = msk(idx + k);
        sh[idx + k] = (sh[idx + k] & ~m) | (d[k] & m);
      end
    @(posedge clock);
    request_pin_first_n <= 1'($urandom);
    request_pin_second_n <= 1'($urandom);
    request_pin_third_n <= 1'($urandom);
    repeat (6) @(posedge clock);
    host_u.read_blk(idx[7:0], cnt + 1, cb, q, ok);
    check(ok, 1'b1); // read framing acked
    check(cb, sh[8]); // count comes first
    for (int k = 0; k <= cnt; k++)
      check(q[k], (idx + k < 14) ? sh[idx + k] : 8'h00); // bytes
    check(outs, exp_outs()); // outputs
  endtask
  initial
  begin
    #1_000_000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    int idx, n;
    void'($urandom(32'h7cc7b385));
    strap_in <= 3'($urandom);
    // held for 3 scl pulses so the link side sees several scl edges
    host_u.pulses(3);
    @(posedge clock);
    rst <= 1'b0;
    host_u.pulses(3);
    sh = '{{5'h00, strap_in}, CSS_RST_B1, CSS_RST_B2, CSS_RST_B3, CSS_RST_B4, CSS_RST_B5,
      ID_P, {RV_P, MK_P}, CSS_RST_B8, CSS_RST_B9, CSS_RST_B10, CSS_RST_PLL, CSS_RST_PLL,
      CSS_RST_PLL};
    foreach (d[k]) d[k] = 8'($urandom);
    round(8'ha4, 0, 13); // foreign address ignored, reset image
    $display("test reset and refusal done");
    for (int i = 0; i < 11; i++)
    begin
      d[0] = CV[i][7:0];
      round(CSS_ADDR_WRITE, int'(CV[i][11:8]), 1); // spread, origin, masks
    end
    $display("test corner writes done");
    for (int i = 0; i < 8; i++)
    begin
      idx = $urandom_range(13, 0);
      n = $urandom_range(14 - idx, 1);
      foreach (d[k]) d[k] = 8'($urandom);
      round(CSS_ADDR_WRITE, idx, n); // block runs
    end
    $display("test random blocks done");
    report_and_stop();
  end
endmodule
`default_nettype wire
